// ==== rtl/oss_pkg.sv ====
/*
 * Shared constants of the octal switch serial control block: command and
 * status word layout, reset values and timing counts.
 * Assumes a single 200 MHz core clock; every count below is in its cycles.
 */
package oss_pkg;

    // ==========================================================
    // word layout
    // ==========================================================
    localparam int WORD_BITS = 16;
    localparam int NUM_OUT = 8;
    localparam int CMD_ONOFF_LSB = 0;
    localparam int CMD_OLD_LSB = 8;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    localparam logic [7:0] STATUS_UPPER = 8'h00;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam int OUT_FIVE_IDX = 4;
    localparam int OUT_SIX_IDX = 5;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 5;
    // least turn-on and turn-off latency after the select rising edge
    localparam int TURN_ON_LATENCY_MIN_NS = 1000;
    localparam int TURN_OFF_LATENCY_MIN_NS = 1000;
    localparam int TURN_ON_CYC =
        (TURN_ON_LATENCY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_OFF_CYC =
        (TURN_OFF_LATENCY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int APPLY_CYC =
        (TURN_ON_CYC > TURN_OFF_CYC) ? TURN_ON_CYC : TURN_OFF_CYC;
    localparam int APPLY_CNT_W = 8;
    // least time a fault must persist before its status bit sets
    localparam int FAULT_FILTER_DELAY_NS = 100000;
    localparam int FAULT_FILTER_CYC =
        (FAULT_FILTER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAULT_CNT_W = 15;

endpackage : oss_pkg

// ==== rtl/oss_sync2.sv ====
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a level with no relation to its neighbours.
 */
`timescale 1ns/10ps
module oss_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] hold;

    // ==========================================================
    // double flop; meta feeds only the second flop
    // ==========================================================
    // both flops keep d ^ rst_val, so a plain zero reset shows rst_val
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            hold <= '0;
        end
        else
        begin
            meta <= d ^ rst_val;
            hold <= meta;
        end
    end

    assign q = hold ^ rst_val;

endmodule : oss_sync2

// ==== rtl/oss_fault_filter.sv ====
/*
 * Per-output fault persistence filter: a status bit sets only after its
 * qualified fault has stood for the full filter count.
 * Assumes qualified faults arrive on the core clock.
 */
`timescale 1ns/10ps
module oss_fault_filter
    import oss_pkg::*;
#(
    parameter logic [oss_pkg::FAULT_CNT_W-1:0] FILTER_CYC =
        oss_pkg::FAULT_CNT_W'(oss_pkg::FAULT_FILTER_CYC)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic [oss_pkg::NUM_OUT-1:0] fault_qual,
    output logic [oss_pkg::NUM_OUT-1:0] fault_status
);
    logic [FAULT_CNT_W-1:0] cnt [NUM_OUT];

    // ==========================================================
    // persistence counters, restart whenever the fault drops
    // ==========================================================
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_OUT; i++)
            begin
                cnt[i] <= '0;
                fault_status[i] <= 1'b0;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_OUT; i++)
            begin
                if (clear || !fault_qual[i])
                begin
                    cnt[i] <= '0;
                    fault_status[i] <= 1'b0;
                end
                else if (cnt[i] >= FILTER_CYC - 1'b1)
                    fault_status[i] <= 1'b1;
                else
                    cnt[i] <= cnt[i] + 1'b1;
            end
        end
    end

endmodule : oss_fault_filter

// ==== rtl/oss_ctrl.sv ====
/*
 * Serial control of an eight-output power switch: 16-bit shift path,
 * command latch on select rising edge, delayed output apply, direct
 * drive inputs, sleep and power-on reset, filtered fault status.
 * Assumes all pins are asynchronous to clk and the serial clock runs far
 * below clk so that every serial edge is seen after synchronisation.
 */
// Functional notes
// - select low enables output; command applies on rise
// - sample data input on serial clock falling edge
// - shift next bit out on rising edge
// - select high: ignore clock, data; output tri-state
// - one switches output on, zero off
// - one bit per falling edge, sixteen per access
// - any fault reports one, healthy outputs zero; code ignores open load on an on output and overtemp on an off output
// - off with detect current disabled reports zero
// - eight leading zeros, then eight status bits
// - single shift path, most significant bit first
// - enable low forces outputs off and sleep
// - power-on reset on every enable rising edge
// - power-on reset when either supply applies
// - outputs five, six are command OR direct input
// - fault must persist before status bit sets
// - outputs change within bounded latency after select rise
// - upper byte enables detect, lower switches outputs
// - upper status byte always returns zero
`timescale 1ns/10ps
module oss_ctrl
    import oss_pkg::*;
#(
    parameter logic [oss_pkg::FAULT_CNT_W-1:0] FAULT_FILTER_CYCLES =
        oss_pkg::FAULT_CNT_W'(oss_pkg::FAULT_FILTER_CYC)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_cmd_in,
    output logic sdo,
    output logic sdo_oe,
    input wire logic enable,
    input wire logic logic_supply_good,
    input wire logic battery_supply_good,
    input wire logic direct_drive_five,
    input wire logic direct_drive_six,
    input wire logic [oss_pkg::NUM_OUT-1:0] fault_short,
    input wire logic [oss_pkg::NUM_OUT-1:0] fault_open,
    input wire logic [oss_pkg::NUM_OUT-1:0] fault_overtemp,
    output logic [oss_pkg::NUM_OUT-1:0] out_on,
    output logic [oss_pkg::NUM_OUT-1:0] open_load_current_en,
    output logic sleep
);
    import oss_pkg::*;

    // ==========================================================
    // pin synchronisation
    // ==========================================================
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic [NUM_OUT*3-1:0] flt_raw;
    logic [NUM_OUT*3-1:0] flt_s;
    logic cs_s, sclk_s, sdi_s, en_s, vdd_s, bat_s, d5_s, d6_s;

    assign pins_raw = {battery_supply_good, logic_supply_good,
                       direct_drive_six, direct_drive_five,
                       enable, serial_cmd_in, sclk, cs_n};
    assign flt_raw = {fault_overtemp, fault_open, fault_short};

    // select idles high, so it synchronises to one out of reset
    oss_sync2 #(.W(8)) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .d(pins_raw),
        .rst_val(8'h01),
        .q(pins_s)
    );

    oss_sync2 #(.W(NUM_OUT*3)) u_flt_sync (
        .clk(clk),
        .rstn(rstn),
        .d(flt_raw),
        .rst_val('0),
        .q(flt_s)
    );

    assign cs_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[2];
    assign en_s = pins_s[3];
    assign d5_s = pins_s[4];
    assign d6_s = pins_s[5];
    assign vdd_s = pins_s[6];
    assign bat_s = pins_s[7];

    // ==========================================================
    // edge detection on synchronised levels
    // ==========================================================
    logic cs_d, sclk_d, en_d, vdd_d, bat_d;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_d <= 1'b1;
            sclk_d <= 1'b0;
            en_d <= 1'b0;
            vdd_d <= 1'b0;
            bat_d <= 1'b0;
        end
        else
        begin
            cs_d <= cs_s;
            sclk_d <= sclk_s;
            en_d <= en_s;
            vdd_d <= vdd_s;
            bat_d <= bat_s;
        end
    end

    logic cs_fall, cs_rise, sclk_rise, sclk_fall, por;

    assign cs_fall = cs_d && !cs_s;
    assign cs_rise = !cs_d && cs_s;
    // while select is high the serial clock edges are simply not looked at
    assign sclk_rise = !cs_s && sclk_s && !sclk_d;
    assign sclk_fall = !cs_s && !sclk_s && sclk_d;
    // power-on reset on enable or either supply coming up
    assign por = (en_s && !en_d)
        || (vdd_s && !vdd_d) || (bat_s && !bat_d);

    // ==========================================================
    // shift path and bit count
    // ==========================================================
    logic [WORD_BITS-1:0] sreg;
    logic [4:0] bit_cnt;
    logic [NUM_OUT-1:0] fault_status;

    // one register both captures and emits, so bits leave in arrival order
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sreg <= CMD_RESET;
        else if (cs_fall)
            sreg <= {STATUS_UPPER, fault_status};
        else if (sclk_fall)
            sreg <= {sreg[WORD_BITS-2:0], sdi_s};
    end

    // saturating count; longer daisy words keep the last sixteen bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            bit_cnt <= '0;
        else if (cs_fall)
            bit_cnt <= '0;
        else if (sclk_fall && bit_cnt != BIT_COUNT_FULL)
            bit_cnt <= bit_cnt + 1'b1;
    end

    // serial output: driven only while selected, msb on each rising edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            sdo_oe <= !cs_s;
            if (cs_fall)
                sdo <= 1'b0;
            else if (sclk_rise)
                sdo <= sreg[WORD_BITS-1];
        end
    end

    // ==========================================================
    // command latch and delayed apply
    // ==========================================================
    logic [WORD_BITS-1:0] cmd;
    logic [WORD_BITS-1:0] applied;
    logic [APPLY_CNT_W-1:0] apply_cnt;
    logic apply_pend;

    // a short word is dropped rather than applied half shifted
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cmd <= CMD_RESET;
        else if (por)
            cmd <= CMD_RESET;
        else if (cs_rise && bit_cnt == BIT_COUNT_FULL)
            cmd <= sreg;
    end

    // fixed latency sits inside both the turn-on and turn-off windows
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            apply_cnt <= '0;
            apply_pend <= 1'b0;
            applied <= CMD_RESET;
        end
        else if (por)
        begin
            apply_cnt <= '0;
            apply_pend <= 1'b0;
            applied <= CMD_RESET;
        end
        else if (cs_rise && bit_cnt == BIT_COUNT_FULL)
        begin
            apply_cnt <= APPLY_CNT_W'(APPLY_CYC - 2);
            apply_pend <= 1'b1;
        end
        else if (apply_pend && apply_cnt == '0)
        begin
            apply_pend <= 1'b0;
            applied <= cmd;
        end
        else if (apply_pend)
            apply_cnt <= apply_cnt - 1'b1;
    end

    // ==========================================================
    // output drive and sleep
    // ==========================================================
    logic [NUM_OUT-1:0] drive;

    always_comb
    begin
        drive = applied[CMD_ONOFF_LSB +: NUM_OUT];
        drive[OUT_FIVE_IDX] = drive[OUT_FIVE_IDX] | d5_s;
        drive[OUT_SIX_IDX] = drive[OUT_SIX_IDX] | d6_s;
    end

    // enable low overrides everything and parks the device asleep
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_on <= '0;
            open_load_current_en <= '0;
            sleep <= 1'b1;
        end
        else
        begin
            out_on <= en_s ? drive : '0;
            open_load_current_en <= en_s
                ? applied[CMD_OLD_LSB +: NUM_OUT] : '0;
            sleep <= !en_s;
        end
    end

    // ==========================================================
    // fault qualification and filtering
    // ==========================================================
    logic [NUM_OUT-1:0] f_short;
    logic [NUM_OUT-1:0] f_open;
    logic [NUM_OUT-1:0] f_ot;
    logic [NUM_OUT-1:0] fault_qual;

    assign f_short = flt_s[NUM_OUT-1:0];
    assign f_open = flt_s[2*NUM_OUT-1:NUM_OUT];
    assign f_ot = flt_s[3*NUM_OUT-1:2*NUM_OUT];

    // on: short or overtemp; off: only with detect current enabled
    always_comb
    begin
        for (int i = 0; i < NUM_OUT; i++)
        begin
            if (!en_s)
                fault_qual[i] = 1'b0;
            else if (out_on[i])
                fault_qual[i] = f_short[i] || f_ot[i];
            else
                fault_qual[i] = open_load_current_en[i]
                    && (f_open[i] || f_short[i]);
        end
    end

    oss_fault_filter #(.FILTER_CYC(FAULT_FILTER_CYCLES)) u_filter (
        .clk(clk),
        .rstn(rstn),
        .clear(por),
        .fault_qual(fault_qual),
        .fault_status(fault_status)
    );

    // ==========================================================
    // checks
    // ==========================================================
    sequence s_idle_pair;
        cs_s ##1 cs_s;
    endsequence

    a_cmd_on_rise: assert property (@(posedge clk) disable iff (!rstn)
        $changed(cmd) |-> $past(cs_rise) || $past(por))
        else $error("command changed outside select rise or reset");

    a_sample_fall: assert property (@(posedge clk) disable iff (!rstn)
        (sclk_fall && !cs_fall) |=> sreg[0] == $past(sdi_s))
        else $error("data input not sampled on falling edge");

    a_shift_out: assert property (@(posedge clk) disable iff (!rstn)
        (sclk_rise && !cs_fall) |=> sdo == $past(sreg[WORD_BITS-1]))
        else $error("serial output missed shift on rising edge");

    a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
        s_idle_pair |-> $stable(sreg) && !sdo_oe)
        else $error("activity while deselected");

    a_status_upper: assert property (@(posedge clk) disable iff (!rstn)
        cs_fall |=> sreg[WORD_BITS-1:NUM_OUT] == STATUS_UPPER
        && sreg[NUM_OUT-1:0] == $past(fault_status))
        else $error("status word loaded wrongly");

    a_sleep_off: assert property (@(posedge clk) disable iff (!rstn)
        !en_s |=> out_on == '0 && open_load_current_en == '0 && sleep)
        else $error("outputs active while disabled");

    a_por_clear: assert property (@(posedge clk) disable iff (!rstn)
        por |=> cmd == CMD_RESET ##1 out_on == '0 || d5_s || d6_s)
        else $error("power-on reset did not clear commands");

    a_direct_or: assert property (@(posedge clk) disable iff (!rstn)
        en_s |=> out_on[OUT_FIVE_IDX] ==
        ($past(applied[OUT_FIVE_IDX]) | $past(d5_s)))
        else $error("direct drive five not combined");

    // age of the last accepted word; saturates while nothing is pending
    logic [APPLY_CNT_W-1:0] lat_age;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lat_age <= '1;
        else if (!por && cs_rise && bit_cnt == BIT_COUNT_FULL)
            lat_age <= '0;
        else if (!por && lat_age != '1)
            lat_age <= lat_age + 1'b1;
        else
            lat_age <= '1;
    end

    a_apply_hold: assert property (@(posedge clk) disable iff (!rstn)
        lat_age < APPLY_CNT_W'(APPLY_CYC - 1) |-> $stable(applied))
        else $error("command applied before least latency");

    a_apply_lat: assert property (@(posedge clk) disable iff (!rstn)
        lat_age == APPLY_CNT_W'(APPLY_CYC - 1) |-> applied == cmd)
        else $error("command not applied within latency");

    a_off_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (!out_on[2] && !open_load_current_en[2])[*2]
        |-> !fault_status[2])
        else $error("status set for off output without detect");

endmodule : oss_ctrl

// ==== tb/oss_host_model.sv ====
/*
 * Host side of the serial link: drives select, serial clock and data,
 * and collects the returned word msb first.
 * Assumes the 200 MHz bench clock; one serial bit takes 25 cycles (125 ns).
 */
`timescale 1ns/10ps
module oss_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic serial_cmd_in,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic last_sdo;
    logic sdo_line;

    // ======================================================
    // line resolution
    // ======================================================
    // a released output has no pull, so show the inverse of its last level
    assign sdo_line = sdo_oe ? sdo : ~last_sdo;

    // remember the last driven level of the returned data
    always @(posedge clk)
    begin
        if (sdo_oe)
            last_sdo <= sdo;
    end

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_cmd_in = 1'b0;
        last_sdo = 1'b0;
    end

    // ======================================================
    // transfers
    // ======================================================
    // one access; nbits below sixteen makes a deliberately short word
    task automatic xfer(input logic [15:0] word, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (12) @(posedge clk);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            serial_cmd_in <= word[i];
            repeat (7) @(posedge clk);
            sclk <= 1'b1;
            repeat (12) @(posedge clk);
            rx = {rx[14:0], sdo_line};
            sclk <= 1'b0;
            repeat (6) @(posedge clk);
        end
        repeat (7) @(posedge clk);
        cs_n <= 1'b1;
        serial_cmd_in <= ~serial_cmd_in;
    endtask : xfer

    // clock and data noise with select high; ends with the clock low
    task automatic idle_noise();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            sclk <= ~sclk;
            serial_cmd_in <= ~serial_cmd_in;
            repeat (12) @(posedge clk);
        end
    endtask : idle_noise

endmodule : oss_host_model

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the serial switch control with a host model.
 * Assumes oss_pkg and the design files are compiled first.
 */
`timescale 1ns/10ps
module testbench;
    import oss_pkg::*;
    // power-on settle shortened from 100 us to keep the run short
    localparam int POR_WAIT = 200;
    logic clk, rstn, cs_n, sclk, serial_cmd_in, sdo, sdo_oe, sleep;
    logic enable, logic_supply_good, battery_supply_good;
    logic direct_drive_five, direct_drive_six;
    logic [7:0] fault_short, fault_open, fault_overtemp;
    logic [7:0] out_on, open_load_current_en;
    logic [15:0] m_cmd, rx, word;
    logic [31:0] seed;
    int error_cnt, checks_done, cyc;

    oss_ctrl #(.FAULT_FILTER_CYCLES(15'h0028)) dut_u (.clk(clk),
        .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .serial_cmd_in(serial_cmd_in),
        .sdo(sdo), .sdo_oe(sdo_oe), .enable(enable),
        .logic_supply_good(logic_supply_good),
        .battery_supply_good(battery_supply_good),
        .direct_drive_five(direct_drive_five),
        .direct_drive_six(direct_drive_six), .fault_short(fault_short),
        .fault_open(fault_open), .fault_overtemp(fault_overtemp),
        .out_on(out_on), .open_load_current_en(open_load_current_en),
        .sleep(sleep));
    oss_host_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk),
        .serial_cmd_in(serial_cmd_in), .sdo(sdo), .sdo_oe(sdo_oe));

    // ======================================================
    // clock, timeout and helpers
    // ======================================================
    always #2.5 clk = ~clk;

    // hang guard: the whole sequence needs well under 30000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            test_done();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // expected returned word from the model command and the fault pins
    function automatic logic [15:0] exp_status();
        logic [7:0] on;
        logic [7:0] st;
        on = m_cmd[7:0];
        st = (on & (fault_short | fault_overtemp))
            | (~on & m_cmd[15:8] & (fault_open | fault_short));
        return enable ? {8'h00, st} : 16'h0000;
    endfunction : exp_status

    task automatic check_outs();
        logic [7:0] v;
        v = m_cmd[7:0];
        v[OUT_FIVE_IDX] = v[OUT_FIVE_IDX] | direct_drive_five;
        v[OUT_SIX_IDX] = v[OUT_SIX_IDX] | direct_drive_six;
        check("out_on", {8'h00, out_on}, enable ? {8'h00, v} : 16'h0);
        check("detect_en", {8'h00, open_load_current_en},
              enable ? {8'h00, m_cmd[15:8]} : 16'h0);
        check("sleep", {15'h0, sleep}, {15'h0, ~enable});
    endtask : check_outs

    // full access: old outputs hold until well after select rises
    task automatic send(input logic [15:0] w);
        logic [15:0] st;
        st = exp_status();
        host_u.xfer(w, 16, rx);
        check("status", rx, st);
        repeat (190) @(posedge clk);
        check_outs();
        m_cmd = w;
        repeat (30) @(posedge clk);
        check_outs();
    endtask : send

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ======================================================
    // main sequence
    // ======================================================
    initial
    begin
        clk = 0; rstn = 0; enable = 1; logic_supply_good = 1;
        battery_supply_good = 1; direct_drive_five = 0; direct_drive_six = 0;
        fault_short = 0; fault_open = 0; fault_overtemp = 0;
        m_cmd = CMD_RESET; seed = 32'hC162; error_cnt = 0; checks_done = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (POR_WAIT) @(posedge clk);
        check_outs();
        check("oe_idle", {15'h0, sdo_oe}, 16'h0);
        // random words; the command bit is kept low under a direct drive
        for (int k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            // one change per access: the toggle rate scales with the waits
            direct_drive_five <= seed[16];
            direct_drive_six <= seed[17];
            word = seed[15:0] & ~{10'h0, seed[17], seed[16], 4'h0};
            send(word);
        end
        direct_drive_five <= 1'b0;
        direct_drive_six <= 1'b0;
        // a short word must leave the command alone
        host_u.xfer(~m_cmd, 15, rx);
        repeat (230) @(posedge clk);
        check_outs();
        host_u.idle_noise();
        repeat (230) @(posedge clk);
        check_outs();
        check("oe_idle", {15'h0, sdo_oe}, 16'h0);
        // faults: on output short, off output open with and without detect
        send(16'h0201);
        fault_short <= 8'h01;
        fault_open <= 8'h06;
        fault_overtemp <= 8'h80;
        host_u.xfer(16'h0201, 16, rx);
        check("early_status", rx, 16'h0000);
        repeat (100) @(posedge clk);
        check("model_status", exp_status(), 16'h0003);
        send(16'h0201);
        fault_short <= 8'h00;
        fault_open <= 8'h00;
        fault_overtemp <= 8'h00;
        // sleep, then a power-on reset from the enable rise
        enable <= 1'b0;
        repeat (10) @(posedge clk);
        check_outs();
        enable <= 1'b1;
        m_cmd = CMD_RESET;
        repeat (POR_WAIT) @(posedge clk);
        check_outs();
        // supply re-application resets as well, each supply in turn
        for (int s = 0; s < 2; s++)
        begin
            send(16'hFF5A);
            if (s == 0) logic_supply_good <= 1'b0;
            else battery_supply_good <= 1'b0;
            repeat (10) @(posedge clk);
            logic_supply_good <= 1'b1;
            battery_supply_good <= 1'b1;
            m_cmd = CMD_RESET;
            repeat (POR_WAIT) @(posedge clk);
            check_outs();
        end
        test_done();
    end

endmodule : testbench
